// ### core/wdu_top.sv
// Operation
// - counter runs on separate watchdog oscillator
// - clear instruction zeroes the counter
// - disable or chip reset zeroes counter
// - enabled counter reaching timeout resets chip
// - select code doubles timeout from 16384
// - unlock bit self-clears four cycles later
// - enable zero ignored unless unlocked
// - level one starts with watchdog disabled
// - level one enables on any one
// - level two always enabled, reads one
// - level two ignores enable in change
// - top three control bits read zero
// - bandgap on for fuse, select, converter
// - timeout gives one-cycle pulse, then delay
// - timeout sets cause flag, zero clears
//
// Added by the designer: the placing of the registers and the plain strobed port.
module wdu_top #(
    parameter int TIMEOUT_BASE = wdu_pkg::TIMEOUT_BASE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic osc_clk,
    input wire logic por_clear,
    input wire logic [wdu_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [wdu_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [wdu_pkg::DATA_W-1:0] reg_rdata,
    input wire logic dog_clear_instruction,
    input wire logic always_on_fuse,
    input wire logic brownout_enable_fuse,
    input wire logic comparator_bandgap_select,
    input wire logic converter_enable,
    output logic chip_reset_pulse,
    output logic reset_delay_start,
    output logic bandgap_power_on,
    output logic dog_irq
);
    import wdu_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // system-domain declarations
    logic dog_enable;
    logic next_dog_enable;
    logic [SEL_W-1:0] timeout_select;
    logic [SEL_W-1:0] next_timeout_select;
    logic [UNLOCK_W-1:0] unlock_cnt;
    logic [UNLOCK_W-1:0] next_unlock_cnt;
    logic change_unlock;
    logic effective_enable;
    logic clr_tgl;
    logic next_clr_tgl;
    logic to_seen;
    logic next_to_seen;
    logic to_sync;
    logic timeout_evt;
    logic lapse_evt;
    logic next_chip_reset_pulse;
    logic next_reset_delay_start;
    logic cause_flag;
    logic next_cause_flag;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [IRQ_W-1:0] next_irq_enable;
    logic [DATA_W-1:0] next_reg_rdata;
    logic next_bandgap_power_on;
    logic wr_control;
    logic arm_write;
    logic second_write;

    ////////////////////////////////////////////////////////////////////////
    // oscillator-domain declarations
    logic osc_rst;
    logic en_sync;
    logic [SEL_W-1:0] sel_sync;
    logic clr_sync;
    logic [SEL_W-1:0] sel_prev;
    logic [SEL_W-1:0] next_sel_prev;
    logic [SEL_W-1:0] sel_held;
    logic [SEL_W-1:0] next_sel_held;
    logic clr_seen;
    logic next_clr_seen;
    logic [CNT_W-1:0] dog_cnt;
    logic [CNT_W-1:0] next_dog_cnt;
    logic [CNT_W-1:0] dog_limit;
    logic to_tgl;
    logic next_to_tgl;

    ////////////////////////////////////////////////////////////////////////
    // crossings between the two domains
    // the select word is multi-bit; it is only taken once two samples agree
    wdu_sync #(.WIDTH(1)) u_rst_sync (
        .clk(osc_clk),
        .async_in(rst),
        .sync_out(osc_rst)
    );

    wdu_sync #(.WIDTH(1)) u_en_sync (
        .clk(osc_clk),
        .async_in(effective_enable),
        .sync_out(en_sync)
    );

    wdu_sync #(.WIDTH(SEL_W)) u_sel_sync (
        .clk(osc_clk),
        .async_in(timeout_select),
        .sync_out(sel_sync)
    );

    wdu_sync #(.WIDTH(1)) u_clr_sync (
        .clk(osc_clk),
        .async_in(clr_tgl),
        .sync_out(clr_sync)
    );

    wdu_sync #(.WIDTH(1)) u_to_sync (
        .clk(sys_clk),
        .async_in(to_tgl),
        .sync_out(to_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // oscillator-domain counter
    assign dog_limit = CNT_W'(TIMEOUT_BASE) << sel_held;

    always_comb begin
        next_sel_prev = sel_sync;
        next_sel_held = sel_held;
        next_clr_seen = clr_sync;
        next_to_tgl = to_tgl;
        next_dog_cnt = dog_cnt + CNT_W'(1);
        if (sel_sync == sel_prev) begin
            next_sel_held = sel_sync;
        end
        if (!en_sync) begin
            next_dog_cnt = '0;
        end else if (clr_sync != clr_seen) begin
            next_dog_cnt = '0;
        end else if (dog_cnt == dog_limit - CNT_W'(1)) begin
            next_dog_cnt = '0;
            next_to_tgl = ~to_tgl;
        end
    end

    // chip reset reaches this domain through its own synchroniser
    always_ff @(posedge osc_clk) begin
        if (osc_rst) begin
            sel_prev <= RST_SELECT;
            sel_held <= RST_SELECT;
            clr_seen <= 1'b0;
            dog_cnt <= '0;
            to_tgl <= 1'b0;
        end else begin
            sel_prev <= next_sel_prev;
            sel_held <= next_sel_held;
            clr_seen <= next_clr_seen;
            dog_cnt <= next_dog_cnt;
            to_tgl <= next_to_tgl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register write decode
    assign wr_control = reg_wr && (reg_addr == OFS_CONTROL);
    assign arm_write = wr_control && reg_wdata[BIT_UNLOCK] && reg_wdata[BIT_ENABLE];
    assign second_write = wr_control && change_unlock && !reg_wdata[BIT_UNLOCK];
    assign change_unlock = (unlock_cnt != '0);
    assign effective_enable = dog_enable || always_on_fuse;

    always_comb begin
        next_dog_enable = dog_enable;
        next_timeout_select = timeout_select;
        next_unlock_cnt = unlock_cnt;
        if (unlock_cnt != '0) begin
            next_unlock_cnt = unlock_cnt - UNLOCK_W'(1);
        end
        if (arm_write) begin
            // arming also writes enable as one, which is its own value
            next_dog_enable = 1'b1;
            next_unlock_cnt = UNLOCK_CYCLES;
        end else if (second_write) begin
            next_unlock_cnt = '0;
            next_timeout_select = reg_wdata[SEL_LSB +: SEL_W];
            if (!always_on_fuse) begin
                next_dog_enable = reg_wdata[BIT_ENABLE];
            end
        end else if (wr_control && reg_wdata[BIT_ENABLE]) begin
            next_dog_enable = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dog_enable <= RST_ENABLE;
            timeout_select <= RST_SELECT;
            unlock_cnt <= '0;
        end else begin
            dog_enable <= next_dog_enable;
            timeout_select <= next_timeout_select;
            unlock_cnt <= next_unlock_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clear instruction and timeout event handling
    // a toggle seen while chip reset is held is stale and must not set the cause flag
    assign timeout_evt = (to_sync != to_seen) && effective_enable && !rst;
    // a window that runs out unused is reported, it often hides a slow handler
    assign lapse_evt = (unlock_cnt == UNLOCK_W'(1)) && !arm_write && !second_write;

    always_comb begin
        next_clr_tgl = clr_tgl;
        next_to_seen = to_sync;
        next_chip_reset_pulse = timeout_evt;
        next_reset_delay_start = chip_reset_pulse;
        if (dog_clear_instruction) begin
            next_clr_tgl = ~clr_tgl;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clr_tgl <= 1'b0;
            to_seen <= to_sync; // tracks the toggle so no false edge follows reset
            chip_reset_pulse <= 1'b0;
            reset_delay_start <= 1'b0;
        end else begin
            clr_tgl <= next_clr_tgl;
            to_seen <= next_to_seen;
            chip_reset_pulse <= next_chip_reset_pulse;
            reset_delay_start <= next_reset_delay_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset cause flag: survives chip reset, only power-on or software clear it
    always_comb begin
        next_cause_flag = cause_flag;
        if (reg_wr && (reg_addr == OFS_CAUSE) && !reg_wdata[BIT_CAUSE]) begin
            next_cause_flag = 1'b0;
        end
        if (timeout_evt) begin
            next_cause_flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (por_clear) begin
            cause_flag <= RST_CAUSE;
        end else begin
            cause_flag <= next_cause_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, clear and enable
    always_comb begin
        next_irq_status = irq_status;
        next_irq_enable = irq_enable;
        if (reg_wr && (reg_addr == OFS_IRQ_CLEAR)) begin
            next_irq_status = irq_status & ~reg_wdata[IRQ_W-1:0];
        end
        if (reg_wr && (reg_addr == OFS_IRQ_ENABLE)) begin
            next_irq_enable = reg_wdata[IRQ_W-1:0];
        end
        // set after clear so a same-cycle event is never lost
        if (timeout_evt) begin
            next_irq_status[IRQ_TIMEOUT] = 1'b1;
        end
        if (lapse_evt) begin
            next_irq_status[IRQ_LAPSE] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_status <= RST_IRQ;
            irq_enable <= RST_IRQ;
        end else begin
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
        end
    end

    assign dog_irq = |(irq_status & irq_enable);

    ////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe, zero otherwise
    always_comb begin
        next_reg_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CONTROL: begin
                    next_reg_rdata[BIT_UNLOCK] = change_unlock;
                    next_reg_rdata[BIT_ENABLE] = effective_enable;
                    next_reg_rdata[SEL_LSB +: SEL_W] = timeout_select;
                end
                OFS_CAUSE: begin
                    next_reg_rdata[BIT_CAUSE] = cause_flag;
                end
                OFS_IRQ_STATUS: begin
                    next_reg_rdata[IRQ_W-1:0] = irq_status;
                end
                OFS_IRQ_ENABLE: begin
                    next_reg_rdata[IRQ_W-1:0] = irq_enable;
                end
                default: begin
                    next_reg_rdata = '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference power is a plain OR; start-up wait is left to software
    assign next_bandgap_power_on = brownout_enable_fuse || comparator_bandgap_select
        || converter_enable;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= '0;
            bandgap_power_on <= 1'b0;
        end else begin
            reg_rdata <= next_reg_rdata;
            bandgap_power_on <= next_bandgap_power_on;
        end
    end

endmodule : wdu_top

// ### core/wdu_pkg.sv
package wdu_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CAUSE = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h03;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h04;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BIT_UNLOCK = 4;
    localparam int BIT_ENABLE = 3;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 3;
    localparam int BIT_CAUSE = 0;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_LAPSE = 1;
    localparam int IRQ_W = 2;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic RST_ENABLE = 1'b0;
    localparam logic [SEL_W-1:0] RST_SELECT = 3'h0;
    localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
    localparam logic RST_CAUSE = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int UNLOCK_W = 3;
    localparam logic [UNLOCK_W-1:0] UNLOCK_CYCLES = 3'h4;
    localparam int CNT_W = 22;
    localparam int TIMEOUT_BASE_CYCLES = 16384;

endpackage : wdu_pkg

// ### core/wdu_sync.sv
// two-flop level synchroniser; the first stage feeds only the second
module wdu_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // no reset: the chain settles within two edges of any clock
    always_ff @(posedge clk) begin
        stage1 <= async_in;
        sync_out <= stage1;
    end

endmodule : wdu_sync

// ### testbench/wdu_top_sva.sv
// watches the top ports; the osc domain is seen only through its effects on the system side
module wdu_top_sva
    import wdu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [wdu_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [wdu_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [wdu_pkg::DATA_W-1:0] reg_rdata,
    input wire logic always_on_fuse,
    input wire logic brownout_enable_fuse,
    input wire logic comparator_bandgap_select,
    input wire logic converter_enable,
    input wire logic chip_reset_pulse,
    input wire logic reset_delay_start,
    input wire logic bandgap_power_on
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // control accesses
    sequence s_arm;
        reg_wr && reg_addr == OFS_CONTROL && reg_wdata[BIT_UNLOCK] && reg_wdata[BIT_ENABLE];
    endsequence
    sequence s_ctl_rd;
        reg_rd && !reg_wr && reg_addr == OFS_CONTROL;
    endsequence
    property p_unlock_holds;
        s_arm ##1 !reg_wr ##1 s_ctl_rd |=> reg_rdata[BIT_UNLOCK];
    endproperty
    property p_unlock_clears;
        s_arm ##1 (!reg_wr) [*5] ##1 s_ctl_rd |=> !reg_rdata[BIT_UNLOCK];
    endproperty
    property p_reserved;
        s_ctl_rd |=> reg_rdata[7:5] == 3'h0;
    endproperty
    property p_fuse_one;
        s_ctl_rd ##0 always_on_fuse |=> reg_rdata[BIT_ENABLE];
    endproperty
    ////////////////////////////////////////////////////////////////////////
    // reset request and reference power
    property p_pulse_one;
        chip_reset_pulse |=> !chip_reset_pulse;
    endproperty
    property p_delay_after;
        chip_reset_pulse |=> reset_delay_start;
    endproperty
    property p_delay_cause;
        reset_delay_start |-> $past(chip_reset_pulse);
    endproperty
    property p_bg_on;
        brownout_enable_fuse || comparator_bandgap_select || converter_enable |=> bandgap_power_on;
    endproperty
    property p_bg_off;
        !(brownout_enable_fuse || comparator_bandgap_select || converter_enable) |=> !bandgap_power_on;
    endproperty
    a_unlock_holds: assert property (p_unlock_holds) else $error("unlock lost early");
    a_unlock_clears: assert property (p_unlock_clears) else $error("unlock stuck");
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    a_fuse_one: assert property (p_fuse_one) else $error("enable reads 0 under fuse");
    a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");
    a_delay_after: assert property (p_delay_after) else $error("delay start missing");
    a_delay_cause: assert property (p_delay_cause) else $error("delay start without pulse");
    a_bg_on: assert property (p_bg_on) else $error("reference off");
    a_bg_off: assert property (p_bg_off) else $error("reference on");
endmodule : wdu_top_sva

bind wdu_top wdu_top_sva wdu_top_sva_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .always_on_fuse(always_on_fuse), .brownout_enable_fuse(brownout_enable_fuse),
    .comparator_bandgap_select(comparator_bandgap_select), .converter_enable(converter_enable),
    .chip_reset_pulse(chip_reset_pulse), .reset_delay_start(reset_delay_start),
    .bandgap_power_on(bandgap_power_on));

// ### testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import wdu_pkg::*;
    localparam int BASE = 8;
    localparam int OSC = 100; // system cycles per oscillator cycle
    logic sys_clk = 0, rst = 1, osc_clk = 0, por_clear = 1, reg_wr = 0, reg_rd = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, rv;
    logic dog_clear_instruction = 0, always_on_fuse = 0;
    logic brownout_enable_fuse = 0, comparator_bandgap_select = 0, converter_enable = 0;
    logic chip_reset_pulse, reset_delay_start, bandgap_power_on, dog_irq;
    int fail_count = 0, checks = 0, cyc = 0, n;

    wdu_top #(.TIMEOUT_BASE(BASE)) wdu_top_inst (.sys_clk(sys_clk), .rst(rst), .osc_clk(osc_clk),
        .por_clear(por_clear), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dog_clear_instruction(dog_clear_instruction),
        .always_on_fuse(always_on_fuse), .brownout_enable_fuse(brownout_enable_fuse),
        .comparator_bandgap_select(comparator_bandgap_select), .converter_enable(converter_enable),
        .chip_reset_pulse(chip_reset_pulse), .reset_delay_start(reset_delay_start),
        .bandgap_power_on(bandgap_power_on), .dog_irq(dog_irq));
    ////////////////////////////////////////////////////////////////////////
    // clocks: the oscillator is offset so its edges never line up with sys_clk
    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        #3;
        forever #500 osc_clk = ~osc_clk;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // helpers
    task print_verdict;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    // long hold: the oscillator side needs three of its own edges to clear
    task reset_dut;
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (4 * OSC) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : reset_dut
    // counts cycles until a reset pulse or the limit, whichever comes first
    task watch(input int hi);
        n = 0;
        while (chip_reset_pulse !== 1'b1 && n < hi) begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask : watch
    task pulse_clear;
        @(posedge sys_clk);
        dog_clear_instruction <= 1'b1;
        @(posedge sys_clk);
        dog_clear_instruction <= 1'b0;
    endtask : pulse_clear
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_timeout;
        rd(OFS_CONTROL); chk(rv, 8'h00);
        rd(8'h3C); chk(rv, 8'h00);
        wr(OFS_CONTROL, 8'hE8); rd(OFS_CONTROL); chk(rv, 8'h08);
        watch(14 * OSC); chk(8'(n >= 8 * OSC && n < 14 * OSC), 8'h01);
        rd(OFS_IRQ_STATUS); chk(rv, 8'h01);
        chk({7'h0, dog_irq}, 8'h00);
        wr(OFS_IRQ_ENABLE, 8'h01); #1 chk({7'h0, dog_irq}, 8'h01);
        wr(OFS_IRQ_CLEAR, 8'h01); #1 chk({7'h0, dog_irq}, 8'h00);
        rd(OFS_CAUSE); chk(rv, 8'h01);
        reset_dut();
        rd(OFS_CAUSE); chk(rv, 8'h01);
        rd(OFS_CONTROL); chk(rv, 8'h00);
        wr(OFS_CAUSE, 8'h00); rd(OFS_CAUSE); chk(rv, 8'h00);
    endtask : t_timeout
    task t_clear;
        wr(OFS_CONTROL, 8'h08);
        repeat (6) begin
            repeat (2 * OSC) @(posedge sys_clk);
            pulse_clear();
        end
        rd(OFS_IRQ_STATUS); chk(rv, 8'h00);
        watch(14 * OSC); chk(8'(n >= 7 * OSC && n < 14 * OSC), 8'h01);
        reset_dut();
    endtask : t_clear
    task t_disable;
        wr(OFS_CONTROL, 8'h08); wr(OFS_CONTROL, 8'h00);
        rd(OFS_CONTROL); chk(rv, 8'h08);
        wr(OFS_CONTROL, 8'h18);
        repeat (4) @(posedge sys_clk);
        rd(OFS_CONTROL); chk(rv, 8'h08);
        rd(OFS_IRQ_STATUS); chk(rv, 8'h02);
        wr(OFS_CONTROL, 8'h18); rd(OFS_CONTROL); chk(rv, 8'h18);
        wr(OFS_CONTROL, 8'h00); rd(OFS_CONTROL); chk(rv, 8'h00);
        watch(20 * OSC); chk(8'(n == 20 * OSC), 8'h01);
        wr(OFS_CONTROL, 8'h18); wr(OFS_CONTROL, 8'h09);
        rd(OFS_CONTROL); chk(rv, 8'h09);
        wr(OFS_CONTROL, 8'h0A); rd(OFS_CONTROL); chk(rv, 8'h09);
        pulse_clear();
        watch(22 * OSC); chk(8'(n >= 16 * OSC && n < 22 * OSC), 8'h01);
        reset_dut();
    endtask : t_disable
    task t_level_two;
        always_on_fuse <= 1'b1;
        reset_dut();
        rd(OFS_CONTROL); chk(rv, 8'h08);
        wr(OFS_CONTROL, 8'h00); rd(OFS_CONTROL); chk(rv, 8'h08);
        wr(OFS_CONTROL, 8'h18); wr(OFS_CONTROL, 8'h02);
        rd(OFS_CONTROL); chk(rv, 8'h0A);
        always_on_fuse <= 1'b0;
        reset_dut();
    endtask : t_level_two
    // every combination of the three reference requests
    task t_bandgap;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            {brownout_enable_fuse, comparator_bandgap_select, converter_enable} <= 3'(i);
            repeat (2) @(posedge sys_clk);
            #1 chk({7'h0, bandgap_power_on}, 8'(i != 0));
        end
    endtask : t_bandgap
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        reset_dut();
        por_clear <= 1'b0;
        t_timeout();
        t_clear();
        t_disable();
        t_level_two();
        t_bandgap();
        print_verdict();
    end
endmodule : tb
